// ===== src/nvm_pkg.sv
// Purpose: Shared constants for the parallel programming port
// Assumes: 40 MHz core clock
// Notes:   Commands, latch actions, array sizes, timing counts
package nvm_pkg;
    localparam real CLK_PERIOD_NS = 25.0;
    // Self-timed byte programming, typical figure
    localparam real PROG_BUSY_MS  = 0.7;
    localparam int  BUSY_CYCLES   =
        int'($floor(PROG_BUSY_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int  TIMER_W       = 16;

    // Command bytes
    localparam logic [7:0] CMD_ERASE    = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEP   = 8'h11;
    localparam logic [7:0] CMD_RD_SIG   = 8'h08;
    localparam logic [7:0] CMD_RD_LF    = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EEP   = 8'h03;
    localparam logic [7:0] CMD_RESET    = 8'h00;

    // Latch actions
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;

    // Arrays
    localparam int          FLASH_AW    = 12;
    localparam int          EEP_AW      = 9;
    localparam logic [11:0] ERASE_LAST  = 12'hFFF;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic [7:0]  NO_DATA     = 8'hFF;
    localparam logic [7:0]  BUS_IDLE    = 8'h00;

    // Fuse and lock bit positions in the data byte
    localparam int         FUSE_SER_BIT   = 5;
    localparam int         FUSE_START_BIT = 0;
    localparam int         LOCK1_BIT      = 1;
    localparam int         LOCK2_BIT      = 2;
    localparam logic [3:0] LF_RSVD        = 4'hF;
    localparam logic       NV_BIT_RESET   = 1'b1;

    // Synchroniser reset: {strobe, action, half, wr_n, oe_n, data}
    localparam logic [13:0] SYNC_INIT = 14'h0300;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_BUSY  = 2'b11,
        ST_ERASE = 2'b10
    } prog_state_t;
endpackage

// ===== src/pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to core_clk
// Notes:   Level moves only when stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // Pins and filtered levels
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] next_level;

    assign agree      = ~(ff2 ^ ff3);
    assign next_level = (ff3 & agree) | (level & ~agree);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ff1   <= INIT;
            ff2   <= INIT;
            ff3   <= INIT;
            level <= INIT;
        end else begin
            ff1   <= pin;
            ff2   <= ff1;
            ff3   <= ff2;
            level <= next_level;
        end
    end
endmodule

// ===== src/self_timer.sv
// Purpose: Self-timed programming interval
// Assumes: start is a one-cycle pulse
// Notes:   busy rises the cycle after start, lasts load cycles
`timescale 1ns/10ps
module self_timer (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    // Control
    input  wire logic                       start,
    input  wire logic [nvm_pkg::TIMER_W-1:0] load,
    // Status
    output logic                            busy
);
    logic [nvm_pkg::TIMER_W-1:0] count;
    logic [nvm_pkg::TIMER_W-1:0] next_count;

    assign busy       = (count != '0);
    assign next_count = start ? load : (busy ? count - 1'b1 : count);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule

// ===== src/parallel_nvm_programming_port.sv
// Purpose: Parallel programming port for program memory, EEPROM,
//          fuse and lock bits, with signature readout
// Assumes: Programmer strobes are asynchronous pins
// Notes:   Arrays hold no reset; run chip erase before use
// Contract
// R1: Flash read: command 02, address high, low
// R2: Flash read drives low/high byte by select
// R3: EEPROM write: command 11, address, data, write
// R4: EEPROM read: command 03, drives byte
// R5: Fuse write: bit5 serial enable, bit0 startup
// R6: Fuse pulse 1.0-1.8 ms; no flag activity
// R7: Lock write: zero in bit1/bit2 programs lock
// R8: Only chip erase clears lock bits; rstn also sets them to 1 here
// R9: Command 04 reads locks bits7/6, fuses 5/0
// R10: Command 08 reads signature byte 0 to 2
// R11: Flag released 0.5-0.9 ms after pulse fell
// R12: Long program pulse hides the busy pulse
// R13: Chip erase pulse 5.0-15.0 ms
// R14: Flash 0000-0FFF words, EEPROM 0000-01FF bytes
// R15: Chip erase fills both arrays with ones
// R16: EEPROM write erases target byte first
// R17: Strobe rise: address, data, command or idle
// R18: Program pulse starts byte write, flag low
// R19: Flag is 0 while busy, 1 when ready
// R20: Command 80 erases arrays then locks, not fuses
// R21: Bus driven only while read strobe low
// R22: Command and address held until reloaded
`timescale 1ns/10ps
module parallel_nvm_programming_port #(
    parameter int         BUSY_CYCLES = nvm_pkg::BUSY_CYCLES,
    // Signature values are arbitrary
    parameter logic [7:0] SIG_BYTE0   = 8'h5A,
    parameter logic [7:0] SIG_BYTE1   = 8'hC3,
    parameter logic [7:0] SIG_BYTE2   = 8'h3C
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Programmer strobes and selects
    input  wire logic       latch_strobe,
    input  wire logic       latch_action_bit0,
    input  wire logic       latch_action_bit1,
    input  wire logic       byte_half_select,
    input  wire logic       prog_pulse_n,
    input  wire logic       read_strobe_n,
    // Data bus
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    // Status
    output logic            prog_done_flag,
    output logic            serial_prog_enable_fuse,
    output logic            fast_startup_fuse
);
    function automatic logic [7:0] pick_byte(input logic       sel,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
        pick_byte = sel ? hi : lo;
    endfunction

    logic [13:0]               pins_lvl;
    logic                      ls_lvl;
    logic [1:0]                action;
    logic                      hb_lvl;
    logic                      wr_lvl;
    logic                      oe_lvl;
    logic [7:0]                din;
    logic                      ls_prev;
    logic                      wr_prev;
    logic                      ls_rise;
    logic                      wr_fall;
    logic                      wr_rise;
    logic [7:0]                cmd;
    logic [7:0]                addr_hi;
    logic [7:0]                addr_lo;
    logic [7:0]                data_lo;
    logic [7:0]                data_hi;
    logic                      lock1;
    logic                      lock2;
    logic [11:0]               sweep;
    logic                      timer_busy;
    logic                      start_write;
    logic                      fuse_go;
    logic                      erase_go;
    logic                      byte_write;
    logic                      erase_done;
    logic [nvm_pkg::FLASH_AW-1:0] flash_addr;
    logic [nvm_pkg::EEP_AW-1:0]   eep_addr;
    logic [7:0]                wr_byte;
    logic [7:0]                flash_rd;
    logic [7:0]                lf_byte;
    logic [7:0]                sig_byte;
    logic [7:0]                read_byte;
    logic [15:0]               busy_age;
    nvm_pkg::prog_state_t      state;
    nvm_pkg::prog_state_t      next_state;

    logic [7:0] flash_lo [0:(1 << nvm_pkg::FLASH_AW)-1];
    logic [7:0] flash_hi [0:(1 << nvm_pkg::FLASH_AW)-1];
    logic [7:0] eep      [0:(1 << nvm_pkg::EEP_AW)-1];

    pin_sync #(
        .WIDTH (14),
        .INIT  (nvm_pkg::SYNC_INIT)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pin      ({latch_strobe, latch_action_bit1, latch_action_bit0,
                    byte_half_select, prog_pulse_n, read_strobe_n,
                    data_in}),
        .level    (pins_lvl)
    );

    self_timer u_timer (
        .core_clk (core_clk),
        .rstn     (rstn),
        .start    (start_write),
        .load     (nvm_pkg::TIMER_W'(BUSY_CYCLES)),
        .busy     (timer_busy)
    );

    // Pin levels and edges
    assign ls_lvl  = pins_lvl[13];
    assign action  = pins_lvl[12:11];
    assign hb_lvl  = pins_lvl[10];
    assign wr_lvl  = pins_lvl[9];
    assign oe_lvl  = pins_lvl[8];
    assign din     = pins_lvl[7:0];
    assign ls_rise = ls_lvl & ~ls_prev;
    assign wr_fall = ~wr_lvl & wr_prev;
    assign wr_rise = wr_lvl & ~wr_prev;

    // Operation decode
    assign byte_write  = (cmd == nvm_pkg::CMD_WR_FLASH)
                       | (cmd == nvm_pkg::CMD_WR_EEP)
                       | (cmd == nvm_pkg::CMD_WR_LOCK);
    assign start_write = (state == nvm_pkg::ST_IDLE) & wr_fall
                       & byte_write;                      // see R18
    assign fuse_go     = (state == nvm_pkg::ST_IDLE) & wr_fall
                       & (cmd == nvm_pkg::CMD_WR_FUSE);    // see R5, R6
    assign erase_go    = (state == nvm_pkg::ST_IDLE) & wr_fall
                       & (cmd == nvm_pkg::CMD_ERASE);      // see R20
    assign erase_done  = (state == nvm_pkg::ST_ERASE)
                       & (sweep == nvm_pkg::ERASE_LAST);
    // Separate address spaces
    assign flash_addr  = {addr_hi[3:0], addr_lo};         // see R14
    assign eep_addr    = {addr_hi[0], addr_lo};           // see R14
    assign wr_byte     = pick_byte(hb_lvl, data_lo, data_hi);

    // Read selection
    assign flash_rd  = pick_byte(hb_lvl, flash_lo[flash_addr],
                                 flash_hi[flash_addr]);   // see R2
    assign lf_byte   = {lock1, lock2, serial_prog_enable_fuse,
                        nvm_pkg::LF_RSVD, fast_startup_fuse}; // see R9
    assign sig_byte  = (addr_lo[1:0] == 2'h0) ? SIG_BYTE0 :
                       (addr_lo[1:0] == 2'h1) ? SIG_BYTE1 :
                       (addr_lo[1:0] == 2'h2) ? SIG_BYTE2 :
                       nvm_pkg::NO_DATA;                  // see R10
    assign read_byte =
        (cmd == nvm_pkg::CMD_RD_FLASH)          ? flash_rd :
        (cmd == nvm_pkg::CMD_RD_EEP && !hb_lvl) ? eep[eep_addr] :
        (cmd == nvm_pkg::CMD_RD_LF && hb_lvl)   ? lf_byte :
        (cmd == nvm_pkg::CMD_RD_SIG && !hb_lvl) ? sig_byte :
        nvm_pkg::NO_DATA;                                 // see R4

    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            nvm_pkg::ST_IDLE: begin
                if (erase_go) begin
                    next_state = nvm_pkg::ST_ERASE;
                end else if (start_write) begin
                    next_state = nvm_pkg::ST_WAIT;
                end
            end
            nvm_pkg::ST_WAIT: begin
                if (!timer_busy) begin
                    next_state = nvm_pkg::ST_IDLE;        // see R12
                end else if (wr_rise) begin
                    next_state = nvm_pkg::ST_BUSY;
                end
            end
            nvm_pkg::ST_BUSY: begin
                if (!timer_busy) begin
                    next_state = nvm_pkg::ST_IDLE;        // see R11
                end
            end
            nvm_pkg::ST_ERASE: begin
                if (erase_done) begin
                    next_state = nvm_pkg::ST_IDLE;
                end
            end
            default: next_state = nvm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state          <= nvm_pkg::ST_IDLE;
            prog_done_flag <= 1'b1;
            ls_prev        <= 1'b0;
            wr_prev        <= 1'b1;
            sweep          <= '0;
        end else begin
            state          <= next_state;
            prog_done_flag <= (next_state != nvm_pkg::ST_BUSY); // see R19
            ls_prev        <= ls_lvl;
            wr_prev        <= wr_lvl;
            sweep          <= (state == nvm_pkg::ST_ERASE)
                            ? sweep + 12'h001 : 12'h000;
        end
    end

    // Latches hold until reloaded
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmd     <= nvm_pkg::CMD_RESET;
            addr_hi <= '0;
            addr_lo <= '0;
            data_lo <= '0;
            data_hi <= '0;
        end else if (ls_rise) begin                       // see R22
            case (action)                                 // see R17
                nvm_pkg::ACT_ADDR: begin
                    if (hb_lvl) addr_hi <= din;
                    else addr_lo <= din;
                end
                nvm_pkg::ACT_DATA: begin
                    if (hb_lvl) data_hi <= din;
                    else data_lo <= din;
                end
                nvm_pkg::ACT_CMD: cmd <= din;
                default: ;
            endcase
        end
    end

    // Fuse and lock bits
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lock1                   <= nvm_pkg::NV_BIT_RESET;
            lock2                   <= nvm_pkg::NV_BIT_RESET;
            serial_prog_enable_fuse <= nvm_pkg::NV_BIT_RESET;
            fast_startup_fuse       <= nvm_pkg::NV_BIT_RESET;
        end else begin
            if (erase_done) begin                         // see R8
                lock1 <= 1'b1;
                lock2 <= 1'b1;
            end else if (start_write && cmd == nvm_pkg::CMD_WR_LOCK) begin
                lock1 <= lock1 & data_lo[nvm_pkg::LOCK1_BIT]; // see R7
                lock2 <= lock2 & data_lo[nvm_pkg::LOCK2_BIT];
            end
            if (fuse_go) begin
                serial_prog_enable_fuse <= data_lo[nvm_pkg::FUSE_SER_BIT];
                fast_startup_fuse       <= data_lo[nvm_pkg::FUSE_START_BIT];
            end
        end
    end

    // Arrays: erase fills with ones; flash writes only clear bits, EEPROM writes overwrite
    always_ff @(posedge core_clk) begin
        if (state == nvm_pkg::ST_ERASE) begin             // see R15
            flash_lo[sweep] <= nvm_pkg::ERASED_BYTE;
            flash_hi[sweep] <= nvm_pkg::ERASED_BYTE;
            if (sweep[11:9] == 3'h0) begin
                eep[sweep[8:0]] <= nvm_pkg::ERASED_BYTE;
            end
        end else if (start_write && cmd == nvm_pkg::CMD_WR_FLASH) begin
            if (hb_lvl) begin
                flash_hi[flash_addr] <= flash_hi[flash_addr] & wr_byte;
            end else begin
                flash_lo[flash_addr] <= flash_lo[flash_addr] & wr_byte;
            end
        end else if (start_write && cmd == nvm_pkg::CMD_WR_EEP) begin
            eep[eep_addr] <= data_lo;                     // see R16
        end
    end

    // Data bus
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            data_oe  <= 1'b0;
            data_out <= nvm_pkg::BUS_IDLE;
        end else begin
            data_oe  <= ~oe_lvl;                          // see R21
            data_out <= oe_lvl ? nvm_pkg::BUS_IDLE : read_byte;
        end
    end

    // Checking helper: busy length
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy_age <= '0;
        end else begin
            busy_age <= start_write ? 16'h0000
                      : (timer_busy ? busy_age + 16'h0001 : busy_age);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence flash_read_s;
        !oe_lvl && cmd == nvm_pkg::CMD_RD_FLASH;
    endsequence
    sequence long_pulse_s;
        state == nvm_pkg::ST_WAIT && !timer_busy;
    endsequence

    flash_read_a: assert property (flash_read_s |=> // see R2
        data_oe && data_out == $past(pick_byte(hb_lvl,
            flash_lo[flash_addr], flash_hi[flash_addr])))
        else $error("flash read byte wrong");
    lf_read_a: assert property (!oe_lvl && hb_lvl // see R9
        && cmd == nvm_pkg::CMD_RD_LF |=> data_out[7] == $past(lock1)
        && data_out[6] == $past(lock2))
        else $error("lock readout wrong");
    fuse_quiet_a: assert property (fuse_go |-> // see R6
        prog_done_flag ##1 prog_done_flag ##1 prog_done_flag)
        else $error("flag moved during fuse write");
    lock_clear_a: assert property ($rose(lock1) || $rose(lock2) // see R8
        |-> $past(erase_done))
        else $error("lock bit cleared outside erase");
    busy_time_a: assert property ($fell(timer_busy) // see R11
        |-> busy_age == 16'(BUSY_CYCLES))
        else $error("busy interval length wrong");
    long_pulse_a: assert property (long_pulse_s |=> // see R12
        prog_done_flag [*3])
        else $error("busy pulse after long program pulse");
    flag_busy_a: assert property (state == nvm_pkg::ST_WAIT // see R18
        && wr_rise && timer_busy |=> !prog_done_flag)
        else $error("flag not low after write pulse");
    erase_fill_a: assert property (state == nvm_pkg::ST_ERASE // see R15
        |=> flash_lo[$past(sweep)] == nvm_pkg::ERASED_BYTE)
        else $error("erase left flash byte");
    erase_lock_a: assert property (erase_done |=> // see R20
        lock1 && lock2 && $stable(serial_prog_enable_fuse))
        else $error("erase lock or fuse handling wrong");
    bus_release_a: assert property (oe_lvl |=> !data_oe) // see R21
        else $error("bus driven with read strobe high");
    cmd_hold_a: assert property (!ls_rise |=> $stable(cmd) // see R22
        && $stable(addr_lo))
        else $error("command or address changed");
    eep_write_a: assert property (start_write // see R16
        && cmd == nvm_pkg::CMD_WR_EEP |=> eep[$past(eep_addr)]
        == $past(data_lo))
        else $error("eeprom byte not replaced");
endmodule

// ===== testbench/nvm_programmer_model.sv
// Purpose: Parallel programmer driving the port's strobes and data
// Assumes: Pins change 1 ns after a core_clk rise, held >= 6 cycles
// Notes:   Data lines are inverted while released for a read
`timescale 1ns/10ps
module nvm_programmer_model (
    // Clock
    input  wire logic       core_clk,
    // From the device
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic       prog_done_flag,
    // To the device
    output logic            latch_strobe,
    output logic            latch_action_bit0,
    output logic            latch_action_bit1,
    output logic            byte_half_select,
    output logic            prog_pulse_n,
    output logic            read_strobe_n,
    output logic [7:0]      data_in
);
    initial begin
        latch_strobe = 1'b0;
        {latch_action_bit1, latch_action_bit0} = 2'h3;
        byte_half_select = 1'b0;
        prog_pulse_n = 1'b1;
        read_strobe_n = 1'b1;
        data_in = 8'h00;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One strobe pulse with action, half and byte set up around it
    task automatic latch(input logic [1:0] act, input logic hb,
                         input logic [7:0] val);
        {latch_action_bit1, latch_action_bit0} = act;
        byte_half_select = hb;
        data_in = val;
        step(6);
        latch_strobe = 1'b1;
        step(6);
        latch_strobe = 1'b0;
        step(6);
    endtask

    // Low pulse of n cycles; t is the last cycle with the flag low
    task automatic pulse(input logic hb, input int n, output int t);
        byte_half_select = hb;
        step(6);
        prog_pulse_n = 1'b0;
        t = 0;
        for (int i = 1; i <= n + 60; i++) begin
            if (i == n + 1) begin
                prog_pulse_n = 1'b1;
            end
            step(1);
            if (prog_done_flag !== 1'b1) begin
                t = i;
            end
        end
    endtask

    // Read strobe low with the data lines released
    task automatic read(input logic hb, output logic [7:0] val);
        byte_half_select = hb;
        data_in = ~data_in;
        read_strobe_n = 1'b0;
        step(8);
        val = (data_oe === 1'b1) ? data_out : 8'hXX;
        read_strobe_n = 1'b1;
        step(8);
    endtask
endmodule

// ===== testbench/test_parallel_nvm_programming_port.sv
// Purpose: Self-checking bench for the parallel programming port
// Assumes: Busy time shortened to 20 cycles
// Notes:   Long program pulses are scaled down to tens of cycles
`timescale 1ns/10ps
module test_parallel_nvm_programming_port;
    localparam int BUSY = 20;
    logic       core_clk;
    logic       rstn;
    logic       latch_strobe;
    logic       act0;
    logic       act1;
    logic       hb;
    logic       prog_pulse_n;
    logic       read_strobe_n;
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic       data_oe;
    logic       prog_done_flag;
    logic       serial_fuse;
    logic       startup_fuse;
    int         n_errors;
    int         n_compared;
    int         t;

    parallel_nvm_programming_port #(
        .BUSY_CYCLES(BUSY),
        .SIG_BYTE0  (8'h11),
        .SIG_BYTE1  (8'h22),
        .SIG_BYTE2  (8'h33)
    ) u_parallel_nvm_programming_port (
        .core_clk               (core_clk),
        .rstn                   (rstn),
        .latch_strobe           (latch_strobe),
        .latch_action_bit0      (act0),
        .latch_action_bit1      (act1),
        .byte_half_select       (hb),
        .prog_pulse_n           (prog_pulse_n),
        .read_strobe_n          (read_strobe_n),
        .data_in                (data_in),
        .data_out               (data_out),
        .data_oe                (data_oe),
        .prog_done_flag         (prog_done_flag),
        .serial_prog_enable_fuse(serial_fuse),
        .fast_startup_fuse      (startup_fuse)
    );

    nvm_programmer_model u_nvm_programmer_model (
        .core_clk         (core_clk),
        .data_out         (data_out),
        .data_oe          (data_oe),
        .prog_done_flag   (prog_done_flag),
        .latch_strobe     (latch_strobe),
        .latch_action_bit0(act0),
        .latch_action_bit1(act1),
        .byte_half_select (hb),
        .prog_pulse_n     (prog_pulse_n),
        .read_strobe_n    (read_strobe_n),
        .data_in          (data_in)
    );

    always #12.5 core_clk = ~core_clk;

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] c);
        u_nvm_programmer_model.latch(nvm_pkg::ACT_CMD, 1'b0, c);
    endtask

    task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
        u_nvm_programmer_model.latch(nvm_pkg::ACT_ADDR, 1'b1, hi);
        u_nvm_programmer_model.latch(nvm_pkg::ACT_ADDR, 1'b0, lo);
    endtask

    task automatic dat(input logic b, input logic [7:0] d);
        u_nvm_programmer_model.latch(nvm_pkg::ACT_DATA, b, d);
    endtask

    // Byte write: flag low, back high about BUSY cycles after the fall
    task automatic wr(input logic b, input logic [7:0] d);
        dat(b, d);
        u_nvm_programmer_model.pulse(b, 6, t);
        check("busy end", 16'(t >= BUSY && t <= BUSY + 8), 16'h1);
    endtask

    task automatic rd(input logic b, input logic [7:0] exp);
        logic [7:0] v;
        u_nvm_programmer_model.read(b, v);
        check("read", v, exp);
        check("bus off", data_oe, 1'b0);
    endtask

    task automatic erase();
        cmd(nvm_pkg::CMD_ERASE);
        u_nvm_programmer_model.pulse(1'b0, 30, t);
        check("erase flag", t, 0);
        repeat (4200) @(posedge core_clk);
        #1;
    endtask

    initial begin
        n_errors = 0;
        n_compared = 0;
        repeat (60000) @(posedge core_clk);
        n_errors++;
        stop_test();
    end

    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        check("flag", prog_done_flag, 1'b1);
        check("bus", data_oe, 1'b0);
        erase();
        $display("test erase done");
        cmd(nvm_pkg::CMD_WR_FLASH);
        addr(8'h0F, 8'hFF);
        wr(1'b0, 8'hA5);
        wr(1'b1, 8'h3C);
        addr(8'h00, 8'h00);
        dat(1'b0, 8'h00);
        u_nvm_programmer_model.pulse(1'b0, 40, t);
        check("long pulse", t, 0);
        cmd(nvm_pkg::CMD_RD_FLASH);
        addr(8'h0F, 8'hFF);
        rd(1'b0, 8'hA5);
        rd(1'b1, 8'h3C);
        addr(8'h00, 8'h00);
        rd(1'b0, 8'h00);
        rd(1'b1, 8'hFF);
        $display("test flash done");
        cmd(nvm_pkg::CMD_WR_EEP);
        addr(8'h01, 8'hFF);
        wr(1'b0, 8'h5A);
        wr(1'b0, 8'hC3);
        cmd(nvm_pkg::CMD_RD_EEP);
        rd(1'b0, 8'hC3);
        rd(1'b1, 8'hFF);
        addr(8'h00, 8'hFF);
        rd(1'b0, 8'hFF);
        $display("test eeprom done");
        cmd(nvm_pkg::CMD_WR_LOCK);
        wr(1'b0, 8'hFB);
        cmd(nvm_pkg::CMD_RD_LF);
        rd(1'b1, 8'hBF);
        rd(1'b0, 8'hFF);
        cmd(nvm_pkg::CMD_WR_LOCK);
        wr(1'b0, 8'hFF);
        cmd(nvm_pkg::CMD_RD_LF);
        rd(1'b1, 8'hBF);
        cmd(nvm_pkg::CMD_WR_FUSE);
        dat(1'b0, 8'hDE);
        u_nvm_programmer_model.pulse(1'b0, 60, t);
        check("fuse flag", t, 0);
        check("fuses", {serial_fuse, startup_fuse}, 2'b00);
        cmd(nvm_pkg::CMD_RD_LF);
        rd(1'b1, 8'h9E);
        $display("test lock fuse done");
        erase();
        cmd(nvm_pkg::CMD_RD_LF);
        rd(1'b1, 8'hDE);
        cmd(nvm_pkg::CMD_RD_FLASH);
        addr(8'h0F, 8'hFF);
        rd(1'b0, 8'hFF);
        cmd(nvm_pkg::CMD_RD_EEP);
        addr(8'h01, 8'hFF);
        rd(1'b0, 8'hFF);
        $display("test second erase done");
        cmd(nvm_pkg::CMD_RD_SIG);
        for (int i = 0; i < 3; i++) begin
            u_nvm_programmer_model.latch(nvm_pkg::ACT_ADDR, 1'b0, 8'(i));
            u_nvm_programmer_model.latch(2'h3, 1'b0, 8'h03);
            rd(1'b0, 8'(8'h11 * (i + 1)));
        end
        $display("test signature done");
        stop_test();
    end
endmodule
